//--- inc/serial_pkg.sv
package serial_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] DATA_ADDR = 4'h8;

  // Receiver oversampling points, counted 1 to 16 within a bit
  localparam logic [4:0] RT_FIRST = 5'h01;
  localparam logic [4:0] RT_LAST = 5'h10;
  localparam logic [4:0] RT_START_A = 5'h03;
  localparam logic [4:0] RT_START_B = 5'h05;
  localparam logic [4:0] RT_START_C = 5'h07;
  localparam logic [4:0] RT_DATA_A = 5'h08;
  localparam logic [4:0] RT_DATA_B = 5'h09;
  localparam logic [4:0] RT_DATA_C = 5'h0A;

  // Transmit bit timing and frame lengths in bits
  localparam logic [3:0] TX_TICK_LAST = 4'hF;
  localparam logic [3:0] FRAME_LEN8 = 4'hA;
  localparam logic [3:0] FRAME_LEN9 = 4'hB;
  localparam logic [3:0] DATA_BITS8 = 4'h8;
  localparam logic [3:0] DATA_BITS9 = 4'h9;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avalon_req_type;

  // Control register, bit 8 down to bit 0
  typedef struct packed {
    logic tx_ninth_bit;
    logic rx_full_irq_en;
    logic tx_done_irq_en;
    logic tx_empty_irq_en;
    logic tx_polarity_invert;
    logic nine_bit_mode;
    logic send_break;
    logic tx_enable_bit;
    logic module_enable;
  } ctrl_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_type;

  typedef enum logic [2:0] {
    RX_SEARCH = 3'b001,
    RX_START = 3'b010,
    RX_DATA = 3'b100
  } rx_state_type;

endpackage

//--- logic/serial_char_txrx.sv
// What this block does
// - Transmit 8- or 9-bit characters; 9-bit mode takes bit 8 from tx_ninth_bit.
// - Each rise of tx enable queues an all-ones preamble before buffered data.
// - Loaded characters carry a zero start bit first and a one stop bit last.
// - Data moving to the shifter sets tx_buffer_empty; with its enable, tx interrupt.
// - The transmit line idles at one (zero when inverted) whenever no character is shifting.
// - Clearing module_enable releases both serial pins at once.
// - While send_break is set, all-zero break characters of frame length repeat.
// - After send_break clears, finish the break then send ones before any start.
// - A break is a start bit, all-zero data and a zero stop position.
// - A break sets framing, full and break flags and clears data and ninth bit.
// - Dropping tx enable idles after the character; toggling queues one idle character.
// - Polarity invert flips every transmitted level, idle and break included.
// - tx_done when shifter and buffer are empty and no break or idle pending.
// - rx_ninth_bit holds bit 8 in 9-bit mode, a copy of bit 7 otherwise.
// - A complete character moves to the read buffer unless it is still full (a break clears it even then), and sets rx_buffer_full.
// - Sample at sixteen ticks per bit; resync on start and on one-to-zero data.
// - A start bit is a zero after three ones; counting then begins.
// - Start samples at ticks 3, 5, 7; two ones reject; one stray one is noise.
// - Data bits are the majority of ticks 8, 9, 10; disagreement sets noise.
// - Stop bit majority of ticks 8, 9, 10; zero is framing error; disagreement noise.
// - framing_error sets in the same cycle as rx_buffer_full.
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module serial_char_txrx
  import serial_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Oversampling tick, sixteen per bit, from the baud generator
  input wire logic oversample_tick,
  // Register bus
  input wire serial_pkg::avalon_req_type avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial pins
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_own,
  output logic serial_in_own,
  // Interrupt requests
  output logic tx_irq,
  output logic rx_irq
);
  import serial_pkg::*;

  typedef struct packed {
    ctrl_type ctrl;
    logic bus_ack;
    logic [31:0] readdata;
    logic status_armed;
    tx_state_type tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_tick;
    logic [3:0] tx_bits;
    logic [7:0] tx_buffer;
    logic tx_buffer_empty;
    logic preamble_pending;
    logic after_break;
    logic break_sending;
    logic tx_level;
    logic [1:0] rx_sync;
    logic [2:0] ones_hist;
    rx_state_type rx_state;
    logic [4:0] rt;
    logic [3:0] rx_bitidx;
    logic [2:0] samples;
    logic [8:0] rx_shift;
    logic last_bit;
    logic frame_noise;
    logic [7:0] rx_buffer;
    logic rx_ninth_bit;
    logic rx_buffer_full;
    logic overrun;
    logic noise_flag;
    logic framing_error;
    logic break_detected;
  } state_type;

  state_type cur;
  state_type next;

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic disagree(input logic [2:0] s);
    disagree = (s != 3'b000) && (s != 3'b111);
  endfunction

  logic rx_bit;
  logic tx_done;
  logic bus_done;
  logic tx_bit_end;
  logic tx_slot;
  logic [3:0] frame_len;
  logic [3:0] data_bits;
  logic [4:0] rt_now;
  logic bit_value;
  logic [31:0] status_word;

  assign rx_bit = cur.rx_sync[1];
  assign frame_len = cur.ctrl.nine_bit_mode ? FRAME_LEN9 : FRAME_LEN8;
  assign data_bits = cur.ctrl.nine_bit_mode ? DATA_BITS9 : DATA_BITS8;
  assign bus_done = cur.bus_ack && (avs_req.read || avs_req.write);
  assign tx_bit_end = (cur.tx_state == TX_SEND) && oversample_tick
    && (cur.tx_tick == TX_TICK_LAST);
  // A new character may only be chosen on a tick, at a frame edge
  assign tx_slot = oversample_tick
    && ((cur.tx_state == TX_IDLE) || (tx_bit_end && (cur.tx_bits == 4'h1)));
  assign tx_done = cur.tx_buffer_empty && (cur.tx_state == TX_IDLE)
    && !cur.preamble_pending && !cur.after_break && !cur.ctrl.send_break;
  assign rt_now = (cur.rt == RT_LAST) ? RT_FIRST : cur.rt + 5'h01;
  assign status_word = {23'h0, cur.rx_ninth_bit, cur.rx_state != RX_SEARCH,
    cur.break_detected, cur.framing_error, cur.noise_flag, cur.overrun,
    cur.rx_buffer_full, tx_done, cur.tx_buffer_empty};

  always_comb
  begin
    next = cur;
    bit_value = 1'b0;
    // Bus slave: one wait cycle, then the access completes
    next.bus_ack = (avs_req.read || avs_req.write) && !cur.bus_ack;
    if ((avs_req.read || avs_req.write) && !cur.bus_ack)
    begin
      if (avs_req.address == CTRL_ADDR)
        next.readdata = {23'h0, cur.ctrl};
      else if (avs_req.address == STATUS_ADDR)
        next.readdata = status_word;
      else if (avs_req.address == DATA_ADDR)
        next.readdata = {24'h0, cur.rx_buffer};
      else
        next.readdata = 32'h0;
    end
    if (bus_done && avs_req.write && avs_req.address == CTRL_ADDR)
    begin
      if (avs_req.byteenable[0])
        next.ctrl[7:0] = avs_req.writedata[7:0];
      if (avs_req.byteenable[1])
        next.ctrl[8] = avs_req.writedata[8];
    end
    if (bus_done && avs_req.read && avs_req.address == STATUS_ADDR)
      next.status_armed = 1'b1;
    // Reading status then data clears the receive flags
    if (bus_done && avs_req.read && avs_req.address == DATA_ADDR && cur.status_armed)
    begin
      next.status_armed = 1'b0;
      next.rx_buffer_full = 1'b0;
      next.overrun = 1'b0;
      next.noise_flag = 1'b0;
      next.framing_error = 1'b0;
      next.break_detected = 1'b0;
    end
    // Writing data after a status read fills the transmit buffer
    if (bus_done && avs_req.write && avs_req.address == DATA_ADDR && avs_req.byteenable[0])
    begin
      next.tx_buffer = avs_req.writedata[7:0];
      if (cur.status_armed)
        next.tx_buffer_empty = 1'b0;
      next.status_armed = 1'b0;
    end

    // Transmitter
    // A rising tx enable, first start or toggle, queues one idle character
    if (!cur.ctrl.tx_enable_bit && next.ctrl.tx_enable_bit)
      next.preamble_pending = 1'b1;
    if (oversample_tick && cur.tx_state == TX_SEND)
    begin
      next.tx_tick = cur.tx_tick + 4'h1;
      if (tx_bit_end)
      begin
        next.tx_shift = {1'b1, cur.tx_shift[10:1]};
        next.tx_bits = cur.tx_bits - 4'h1;
      end
    end
    if (tx_slot)
    begin
      next.tx_tick = 4'h0;
      next.tx_bits = frame_len;
      next.tx_state = TX_SEND;
      next.break_sending = 1'b0;
      if (!cur.ctrl.module_enable || !cur.ctrl.tx_enable_bit)
        next.tx_state = TX_IDLE;
      else if (cur.ctrl.send_break)
      begin
        next.tx_shift = 11'h000;
        next.after_break = 1'b1;
        next.break_sending = 1'b1;
      end
      else if (cur.preamble_pending || cur.after_break)
      begin
        // Ones after a break guarantee the next start edge is seen
        next.tx_shift = 11'h7FF;
        next.preamble_pending = 1'b0;
        next.after_break = 1'b0;
      end
      else if (!cur.tx_buffer_empty)
      begin
        if (cur.ctrl.nine_bit_mode)
          next.tx_shift = {1'b1, cur.ctrl.tx_ninth_bit, cur.tx_buffer, 1'b0};
        else
          next.tx_shift = {2'b11, cur.tx_buffer, 1'b0};
        next.tx_buffer_empty = 1'b1;
      end
      else
        next.tx_state = TX_IDLE;
    end
    // The pin follows shifter bit 0 only while a frame is shifting, otherwise the idle level
    if (next.tx_state == TX_SEND)
      next.tx_level = next.tx_shift[0] ^ cur.ctrl.tx_polarity_invert;
    else
      next.tx_level = 1'b1 ^ cur.ctrl.tx_polarity_invert;

    // Receiver
    next.rx_sync = {cur.rx_sync[0], serial_in_pin};
    if (!cur.ctrl.module_enable)
    begin
      next.rx_state = RX_SEARCH;
      next.ones_hist = 3'b000;
    end
    else if (oversample_tick)
    begin
      next.rt = rt_now;
      if (rt_now == RT_START_A || rt_now == RT_START_B || rt_now == RT_START_C
          || rt_now == RT_DATA_A || rt_now == RT_DATA_B || rt_now == RT_DATA_C)
        next.samples = {cur.samples[1:0], rx_bit};
      case (cur.rx_state)
        RX_SEARCH:
        begin
          next.ones_hist = {cur.ones_hist[1:0], rx_bit};
          if (!rx_bit && cur.ones_hist == 3'b111)
          begin
            next.rx_state = RX_START;
            next.rt = RT_FIRST;
            next.frame_noise = 1'b0;
            next.rx_bitidx = 4'h0;
            next.rx_shift = 9'h000;
            next.last_bit = 1'b0;
          end
        end
        RX_START:
        begin
          if (rt_now == RT_START_C)
          begin
            if (majority({cur.samples[1:0], rx_bit}))
            begin
              // Rejected: rt keeps running unused and the search begins again
              next.rx_state = RX_SEARCH;
              next.ones_hist = 3'b000;
            end
            else if (disagree({cur.samples[1:0], rx_bit}))
              next.frame_noise = 1'b1;
          end
          // Late start samples only count as noise, any one among them
          if (rt_now == RT_DATA_C && (|{cur.samples[1:0], rx_bit}))
            next.frame_noise = 1'b1;
          if (rt_now == RT_LAST && next.rx_state == RX_START)
            next.rx_state = RX_DATA;
        end
        RX_DATA:
        begin
          if (rt_now == RT_DATA_C)
          begin
            bit_value = majority({cur.samples[1:0], rx_bit});
            if (disagree({cur.samples[1:0], rx_bit}))
              next.frame_noise = 1'b1;
            next.last_bit = bit_value;
            if (cur.rx_bitidx < data_bits)
              next.rx_shift[cur.rx_bitidx] = bit_value;
            else
            begin
              // Stop position sampled: the frame completes here, break or not
              next.rx_state = RX_SEARCH;
              next.ones_hist = 3'b000;
              // Builds on the cleared value so a same-cycle read cannot undo the set
              next.noise_flag = next.noise_flag | next.frame_noise;
              next.framing_error = !bit_value;
              next.rx_buffer_full = 1'b1;
              if (cur.rx_buffer_full)
                next.overrun = 1'b1;
              if (!bit_value && cur.rx_shift == 9'h000)
              begin
                next.break_detected = 1'b1;
                next.rx_buffer = 8'h00;
                next.rx_ninth_bit = 1'b0;
              end
              else if (!cur.rx_buffer_full)
              begin
                next.rx_buffer = cur.rx_shift[7:0];
                next.rx_ninth_bit = cur.ctrl.nine_bit_mode
                  ? cur.rx_shift[8] : cur.rx_shift[7];
              end
            end
          end
          else if (rt_now > RT_DATA_C && cur.last_bit && !rx_bit
                   && cur.samples[0] && cur.rx_bitidx < data_bits)
          begin
            // Early one-to-zero edge realigns the next bit
            next.rt = RT_FIRST;
            next.rx_bitidx = cur.rx_bitidx + 4'h1;
          end
          if (rt_now == RT_LAST)
            next.rx_bitidx = cur.rx_bitidx + 4'h1;
        end
        default:
          next.rx_state = RX_SEARCH;
      endcase
    end

    if (!rst_n)
    begin
      next = '0;
      next.tx_state = TX_IDLE;
      next.rx_state = RX_SEARCH;
      next.tx_buffer_empty = 1'b1;
      next.tx_level = 1'b1;
      next.rt = RT_FIRST;
    end
  end

  always_ff @(posedge clock)
  begin
    cur <= next;
  end

  assign avs_readdata = cur.readdata;
  assign avs_waitrequest = (avs_req.read || avs_req.write) && !cur.bus_ack;
  assign serial_out_pin = cur.tx_level;
  assign serial_out_own = cur.ctrl.module_enable;
  assign serial_in_own = cur.ctrl.module_enable;
  assign tx_irq = (cur.tx_buffer_empty && cur.ctrl.tx_empty_irq_en)
    || (tx_done && cur.ctrl.tx_done_irq_en);
  assign rx_irq = cur.rx_buffer_full && cur.ctrl.rx_full_irq_en;

  default clocking main_clk @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  idle_level_a: assert property (cur.tx_state == TX_IDLE |-> ##1
    (next.tx_state == TX_SEND || serial_out_pin == !$past(cur.ctrl.tx_polarity_invert)))
    else $error("transmit line not idle while no frame shifts");
  pin_release_a: assert property (!cur.ctrl.module_enable |->
    !serial_out_own && !serial_in_own)
    else $error("pins still owned with module disabled");
  empty_on_load_a: assert property (tx_slot && !cur.tx_buffer_empty
    && cur.ctrl.module_enable && cur.ctrl.tx_enable_bit && !cur.ctrl.send_break
    && !cur.preamble_pending && !cur.after_break |=> cur.tx_buffer_empty && cur.tx_shift[0] == 1'b0)
    else $error("data load did not set empty flag with start bit");
  break_zero_a: assert property (tx_slot && cur.ctrl.module_enable
    && cur.ctrl.tx_enable_bit && cur.ctrl.send_break |=> cur.tx_shift == 11'h000
    && cur.tx_bits == frame_len)
    else $error("break character not all zeros of frame length");
  after_break_a: assert property ($fell(cur.break_sending) && cur.tx_state == TX_SEND
    && !cur.ctrl.send_break |-> cur.tx_shift == 11'h7FF)
    else $error("no ones after break character");
  frame_flags_a: assert property ($rose(cur.framing_error) |-> $rose(cur.rx_buffer_full)
    || $past(cur.rx_buffer_full))
    else $error("framing error set apart from buffer full");
  break_clear_a: assert property ($rose(cur.break_detected) |-> cur.framing_error
    && cur.rx_buffer_full && cur.rx_buffer == 8'h00 && !cur.rx_ninth_bit)
    else $error("break effects on receive registers wrong");
  start_reject_a: assert property (cur.rx_state == RX_START && oversample_tick
    && rt_now == RT_START_C && majority({cur.samples[1:0], rx_bit}) |=> cur.rx_state == RX_SEARCH)
    else $error("start bit with two ones not rejected");
  tx_irq_a: assert property (cur.tx_buffer_empty && cur.ctrl.tx_empty_irq_en |-> tx_irq)
    else $error("empty interrupt missing");
  bus_wait_a: assert property (avs_req.read && !avs_waitrequest |-> $past(avs_req.read))
    else $error("read completed without a wait cycle");

  break_rx_c: cover property ($rose(cur.break_detected));
  char_rx_c: cover property ($rose(cur.rx_buffer_full) && !cur.framing_error);
  noise_c: cover property ($rose(cur.noise_flag));
  data_tx_c: cover property ($rose(cur.tx_buffer_empty));

endmodule

`default_nettype wire

//--- sim/remote_serial.sv
`timescale 1ns/100ps
`default_nettype none

module remote_serial (
  // Clock, reset and oversampling tick
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  // Frame control, bits listed first on the wire at index 0
  input wire logic send_go,
  input wire logic [11:0] send_bits,
  input wire logic [3:0] frame_len,
  output logic busy,
  output logic [11:0] got_bits,
  output logic [7:0] got_count,
  // Line
  input wire logic line_in,
  output logic line_out
);
  logic [11:0] tx_sr;
  logic [3:0] tx_left;
  logic [3:0] tx_ph;
  logic [3:0] rx_left;
  logic [3:0] rx_ph;

  assign busy = tx_left != 4'h0;
  // Released line is pulled up, so idle reads as one
  assign line_out = busy ? tx_sr[0] : 1'b1;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tx_left <= 4'h0;
      rx_left <= 4'h0;
      got_count <= 8'h00;
    end
    else
    begin
      if (send_go && !busy)
      begin
        tx_sr <= send_bits;
        tx_left <= frame_len;
        tx_ph <= 4'h0;
      end
      else if (tick && busy)
      begin
        tx_ph <= tx_ph + 4'h1;
        if (tx_ph == 4'hF)
        begin
          tx_sr <= {1'b1, tx_sr[11:1]};
          tx_left <= tx_left - 4'h1;
        end
      end
      // Capture each bit near its middle, LSB first
      if (tick && rx_left == 4'h0 && !line_in)
      begin
        rx_left <= frame_len;
        rx_ph <= 4'h1;
        got_bits <= 12'h000;
      end
      else if (tick && rx_left != 4'h0)
      begin
        rx_ph <= rx_ph + 4'h1;
        if (rx_ph == 4'h8)
        begin
          got_bits[frame_len - rx_left] <= line_in;
          rx_left <= rx_left - 4'h1;
          if (rx_left == 4'h1)
            got_count <= got_count + 8'h01;
        end
      end
    end
  end
endmodule

`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import serial_pkg::*;
  logic clock;
  logic rst_n;
  logic tick;
  logic wait_req;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [31:0] r;
  avalon_req_type req;
  logic sin;
  logic sout;
  logic out_own;
  logic in_own;
  logic tx_irq;
  logic rx_irq;
  logic go;
  logic busy;
  logic [11:0] frame;
  logic [11:0] got;
  logic [3:0] flen;
  logic [7:0] got_count;
  int failures;
  int tests_run;
  int seed;
  int n;

  serial_char_txrx u_serial_char_txrx (.clock(clock), .rst_n(rst_n), .oversample_tick(tick),
    .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wait_req), .serial_in_pin(sin),
    .serial_out_pin(sout), .serial_out_own(out_own), .serial_in_own(in_own),
    .tx_irq(tx_irq), .rx_irq(rx_irq));

  remote_serial u_remote_serial (.clock(clock), .rst_n(rst_n), .tick(tick), .send_go(go),
    .send_bits(frame), .frame_len(flen), .busy(busy), .got_bits(got),
    .got_count(got_count), .line_in(sout), .line_out(sin));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Tick every other clock keeps frames short
  always @(posedge clock)
    tick <= ~tick;

  function automatic logic [11:0] frame_of(input logic nine, input logic [7:0] d,
    input logic b8, input logic stop);
    frame_of = nine ? {1'b0, stop, b8, d, 1'b0} : {2'b00, stop, d, 1'b0};
  endfunction

  function automatic logic [31:0] rx_status(input logic nine, input logic [7:0] d,
    input logic b8, input logic stop);
    logic brk;
    brk = !stop && d == 8'h00 && !(nine && b8);
    rx_status = {23'h0, brk ? 1'b0 : (nine ? b8 : d[7]), 1'b0, brk, !stop, 2'b00, 1'b1, 2'b00};
  endfunction

  task automatic test_done;
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic give_up;
    failures++;
    test_done();
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    req <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
    @(posedge clock);
    while (wait_req !== 1'b0 && k < 20)
    begin
      @(posedge clock);
      k++;
    end
    if (k == 20)
      give_up();
    // Data and write effect belong to the edge that sees waitrequest low
    q = rdata;
    req <= '0;
    @(negedge clock);
  endtask

  task automatic wait_got(input logic [7:0] old);
    n = 0;
    while (got_count === old && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 3000)
      give_up();
  endtask

  task automatic tx_char(input logic nine, input logic [7:0] d, input logic b8);
    logic [31:0] ctrl;
    logic [7:0] c0;
    c0 = got_count;
    ctrl = {23'h0, b8, 4'hE, nine, 3'b001};
    flen <= nine ? 4'hB : 4'hA;
    bus(1'b1, CTRL_ADDR, ctrl);
    // Rising transmitter enable opens with a preamble
    bus(1'b1, CTRL_ADDR, ctrl | 32'h2);
    bus(1'b0, STATUS_ADDR, 32'h0);
    bus(1'b1, DATA_ADDR, {24'h0, d});
    check("tx irq busy", tx_irq, 32'h0);
    bus(1'b0, STATUS_ADDR, 32'h0);
    check("tx flags busy", q[1:0], 32'h0);
    wait_got(c0);
    check("tx frame", got, frame_of(nine, d, b8, 1'b1));
    check("preamble time", n >= 48 * flen, 32'h1);
    repeat (80) @(negedge clock);
    bus(1'b0, STATUS_ADDR, 32'h0);
    check("tx flags done", q[1:0], 32'h3);
    check("tx irq done", tx_irq, 32'h1);
  endtask

  task automatic rx_char(input logic nine, input logic [7:0] d, input logic b8,
    input logic stop);
    flen <= nine ? 4'hB : 4'hA;
    bus(1'b1, CTRL_ADDR, {23'h0, 1'b0, 4'h8, nine, 3'b001});
    @(posedge clock);
    frame <= frame_of(nine, d, b8, stop);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    n = 0;
    @(negedge clock);
    while (busy !== 1'b0 && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 3000)
      give_up();
    repeat (40) @(negedge clock);
    check("rx irq set", rx_irq, 32'h1);
    bus(1'b0, STATUS_ADDR, 32'h0);
    check("rx status", q & 32'h17C, rx_status(nine, d, b8, stop));
    bus(1'b0, DATA_ADDR, 32'h0);
    check("rx data", q, {24'h0, d});
    check("rx irq clear", rx_irq, 32'h0);
  endtask

  initial
  begin
    rst_n = 1'b0;
    tick = 1'b0;
    req = '0;
    go = 1'b0;
    frame = 12'h000;
    flen = 4'hA;
    failures = 0;
    tests_run = 0;
    seed = 50364;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    check("idle line", sout, 32'h1);
    check("pins at reset", {out_own, in_own}, 32'h0);
    bus(1'b0, STATUS_ADDR, 32'h0);
    check("reset status", q, 32'h3);
    bus(1'b0, 4'hC, 32'h0);
    check("unmapped read", q, 32'h0);
    bus(1'b1, CTRL_ADDR, 32'h1);
    check("pins taken", {out_own, in_own}, 32'h3);
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed);
      tx_char(r[0], r[15:8], r[1]);
      rx_char(r[0], r[23:16], r[2], 1'b1);
    end
    tx_char(1'b1, 8'hFF, 1'b1);
    rx_char(1'b0, 8'h5A, 1'b0, 1'b0);
    rx_char(1'b0, 8'h00, 1'b0, 1'b0);
    rx_char(1'b1, 8'h00, 1'b0, 1'b0);
    rx_char(1'b1, 8'h80, 1'b1, 1'b1);
    flen <= 4'hA;
    r = got_count;
    bus(1'b1, CTRL_ADDR, 32'h7);
    wait_got(r[7:0]);
    check("break frame", got, 32'h0);
    // Transmitter stays on so the ones after the break really go out
    bus(1'b1, CTRL_ADDR, 32'h3);
    repeat (800) @(negedge clock);
    check("idle after break", sout, 32'h1);
    bus(1'b0, STATUS_ADDR, 32'h0);
    check("done after break", q[1:0], 32'h3);
    bus(1'b1, CTRL_ADDR, 32'h11);
    repeat (10) @(negedge clock);
    check("inverted idle", sout, 32'h0);
    bus(1'b1, CTRL_ADDR, 32'h0);
    check("pins released", {out_own, in_own}, 32'h0);
    test_done();
  end
endmodule

`default_nettype wire
